/* rtl/sdc_pkg.sv */
/*
 * Constants, types and helpers of the SDRAM host controller.
 * Assumes one 125 MHz clock shared with the memory.
 */
package sdc_pkg;

    // ********
    // clock and widths
    // ********
    localparam int CLK_PERIOD_NS = 8;
    localparam int BANK_W = 2;
    localparam int NBANK = 4;
    localparam int ROW_W = 12;
    localparam int COL_W = 9;
    localparam int ADDR_W = 12;
    localparam int DQ_W = 16;
    localparam int MASK_W = 2;
    localparam int TMR_W = 16;
    localparam int AUTO_CLOSE_BIT = 10;

    // ********
    // timing, least times rounded up to cycles
    // ********
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ceil_cyc

    localparam int T_PAUSE_US = 200;
    localparam int PAUSE_CYC = ceil_cyc(T_PAUSE_US * 1000);
    localparam int T_RP_NS = 20;
    localparam int T_RCD_NS = 20;
    localparam int T_RC_NS = 70;
    localparam int T_MRD_NS = 16;
    localparam logic [TMR_W-1:0] RP_CYC = TMR_W'(ceil_cyc(T_RP_NS));
    localparam logic [TMR_W-1:0] RCD_CYC = TMR_W'(ceil_cyc(T_RCD_NS));
    localparam logic [TMR_W-1:0] RC_CYC = TMR_W'(ceil_cyc(T_RC_NS));
    localparam logic [TMR_W-1:0] MRD_CYC = TMR_W'(ceil_cyc(T_MRD_NS));
    localparam int CAS_LAT = 2;
    localparam logic [TMR_W-1:0] RD_DONE_CYC = TMR_W'(CAS_LAT + 2);
    localparam logic [TMR_W-1:0] WR_DONE_CYC = TMR_W'(ceil_cyc(T_RP_NS) + 2);
    localparam logic [TMR_W-1:0] ONE_CYC = 16'h0001;
    localparam logic [15:0] REF_INT_CYC = 16'h05DC;
    localparam logic [3:0] INIT_REF_COUNT = 4'h8;

    // mode word: burst one, latency two
    localparam logic [ADDR_W-1:0] MODE_WORD = 12'h020;

    // ********
    // reset levels of the pins
    // ********
    localparam logic RST_CKE = 1'b1;
    localparam logic RST_CS_N = 1'b0;
    localparam logic [2:0] RST_STROBES = 3'h7;
    localparam logic [MASK_W-1:0] RST_MASK = 2'h3;

    // ********
    // commands
    // ********
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_PRE, CMD_READ, CMD_WRITE, CMD_MRS, CMD_REF, CMD_STOP
    } sdc_cmd_t;

    // {row, column, write} strobe levels for a command
    function automatic logic [2:0] cmd_strobes(input sdc_cmd_t c);
        case (c)
            CMD_ACT: return 3'h3;
            CMD_PRE: return 3'h2;
            CMD_READ: return 3'h5;
            CMD_WRITE: return 3'h4;
            CMD_MRS: return 3'h0;
            CMD_REF: return 3'h1;
            CMD_STOP: return 3'h6;
            default: return 3'h7;
        endcase
    endfunction : cmd_strobes

endpackage : sdc_pkg

/* rtl/sdc_timer.sv */
/*
 * Loadable down-counter for every wait of the controller.
 * Assumes its user runs on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sdc_timer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [sdc_pkg::TMR_W-1:0] load_val,
    output logic expired
);
    import sdc_pkg::*;

    typedef struct packed {
        logic [TMR_W-1:0] count;
    } sdc_tmr_st_t;

    sdc_tmr_st_t st_q;
    sdc_tmr_st_t st_d;

    // count down to zero, reload wins over decrement
    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.count = load_val;
        end else if (st_q.count != '0) begin
            st_d.count = st_q.count - ONE_CYC;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign expired = (st_q.count == '0);

endmodule : sdc_timer
`default_nettype wire

/* rtl/sdc_bank_track.sv */
/*
 * Open-row bookkeeping of the four banks.
 * Assumes at most one open or close per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module sdc_bank_track (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic open_en,
    input wire logic close_en,
    input wire logic close_all,
    input wire logic [sdc_pkg::BANK_W-1:0] bank,
    input wire logic [sdc_pkg::ROW_W-1:0] row,
    output logic is_open,
    output logic row_hit,
    output logic any_open
);
    import sdc_pkg::*;

    typedef struct packed {
        logic [NBANK-1:0] active;
        logic [NBANK-1:0][ROW_W-1:0] rows;
    } sdc_bank_st_t;

    sdc_bank_st_t st_q;
    sdc_bank_st_t st_d;

    // a bank closes on precharge, opens on activate
    always_comb begin
        st_d = st_q;
        if (close_all) begin
            st_d.active = '0;
        end else if (close_en) begin
            st_d.active[bank] = 1'b0;
        end else if (open_en) begin
            st_d.active[bank] = 1'b1;
            st_d.rows[bank] = row;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign is_open = st_q.active[bank];
    assign row_hit = st_q.active[bank] && (st_q.rows[bank] == row);
    assign any_open = |st_q.active;

endmodule : sdc_bank_track
`default_nettype wire

/* rtl/sdc_ctrl.sv */
/*
 * SDRAM host controller top: start-up sequencer,
 * single-word access, refresh and power-down.
 * Assumes the device runs on ref_clk; the bench
 * merges sd_dq_out and sd_dq_oe onto the data wires.
 */
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl #(
    parameter int PAUSE_CYCLES = sdc_pkg::PAUSE_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // user request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_auto_close_flag,
    input wire logic [sdc_pkg::BANK_W-1:0] req_bank,
    input wire logic [sdc_pkg::ROW_W-1:0] req_row,
    input wire logic [sdc_pkg::COL_W-1:0] req_col,
    input wire logic [sdc_pkg::DQ_W-1:0] req_wdata,
    input wire logic [sdc_pkg::MASK_W-1:0] req_byte_en,
    input wire logic pd_req,
    output logic rd_valid,
    output logic [sdc_pkg::DQ_W-1:0] rd_data,
    output logic init_done,
    // memory pins
    output logic sd_clk_gate,
    output logic sd_chip_sel_n,
    output logic sd_row_strobe_n,
    output logic sd_col_strobe_n,
    output logic sd_write_n,
    output logic [sdc_pkg::BANK_W-1:0] sd_bank_select,
    output logic [sdc_pkg::ADDR_W-1:0] sd_addr,
    output logic sd_low_byte_mask,
    output logic sd_high_byte_mask,
    output logic [sdc_pkg::DQ_W-1:0] sd_dq_out,
    output logic sd_dq_oe,
    input wire logic [sdc_pkg::DQ_W-1:0] sd_dq_in
);
    import sdc_pkg::*;

    // ********
    // state
    // ********
    typedef enum logic [3:0] {
        S_PAUSE, S_IPRE, S_IMRS, S_INOP, S_IREF, S_IDLE, S_PRE, S_ACT,
        S_RW, S_REF, S_PDN, S_PDX, S_WAIT
    } sdc_state_t;

    typedef struct packed {
        sdc_state_t state;
        sdc_state_t ret;
        logic armed;
        logic cke;
        logic cs_n;
        logic [2:0] strobes;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [MASK_W-1:0] mask;
        logic [DQ_W-1:0] dq_o;
        logic dq_oe;
        logic [3:0] ref_left;
        logic [15:0] ref_tick;
        logic ref_due;
        logic [CAS_LAT+1:0] rd_pipe;
        logic [DQ_W-1:0] dq_s1;
        logic [DQ_W-1:0] dq_s2;
        logic [DQ_W-1:0] rd_data;
        logic rd_valid;
        logic req_ready;
        logic init_done;
        logic l_write;
        logic l_close;
        logic [BANK_W-1:0] l_bank;
        logic [ROW_W-1:0] l_row;
        logic [COL_W-1:0] l_col;
        logic [DQ_W-1:0] l_data;
        logic [MASK_W-1:0] l_be;
    } sdc_ctrl_st_t;

    sdc_ctrl_st_t st_q;
    sdc_ctrl_st_t st_d;

    logic tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic tmr_expired;
    logic bk_open;
    logic bk_close;
    logic bk_close_all;
    logic [BANK_W-1:0] bk_bank;
    logic bk_is_open;
    logic bk_row_hit;
    logic bk_any_open;
    logic [ROW_W-1:0] bk_row;
    logic read_on_pins;

    // ********
    // helpers
    // ********
    sdc_timer u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_expired)
    );

    sdc_bank_track u_banks (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .open_en(bk_open),
        .close_en(bk_close),
        .close_all(bk_close_all),
        .bank(bk_bank),
        .row(bk_row),
        .is_open(bk_is_open),
        .row_hit(bk_row_hit),
        .any_open(bk_any_open)
    );

    // bank lookups follow the request being taken, else the latched one
    // taken from the inputs, not st_d, to keep the lookup loop-free
    assign bk_bank = (st_q.state == S_IDLE) ? req_bank : st_q.l_bank;
    assign bk_row = (st_q.state == S_IDLE) ? req_row : st_q.l_row;

    // a read that the device samples at the next edge
    assign read_on_pins = !st_q.cs_n && st_q.cke && (st_q.strobes == cmd_strobes(CMD_READ));

    // ********
    // next state
    // ********
    always_comb begin
        st_d = st_q;
        tmr_load = 1'b0;
        tmr_val = ONE_CYC;
        bk_open = 1'b0;
        bk_close = 1'b0;
        bk_close_all = 1'b0;
        // default: NOP, masks high, bus released
        st_d.cs_n = 1'b0;
        st_d.strobes = cmd_strobes(CMD_NOP);
        st_d.mask = RST_MASK;
        st_d.dq_oe = 1'b0;
        st_d.cke = 1'b1;
        // data input passes two flops before use
        st_d.dq_s1 = sd_dq_in;
        st_d.dq_s2 = st_q.dq_s1;
        st_d.rd_pipe = {st_q.rd_pipe[CAS_LAT:0], read_on_pins};
        st_d.rd_valid = st_q.rd_pipe[CAS_LAT+1];
        if (st_q.rd_pipe[CAS_LAT+1]) begin
            st_d.rd_data = st_q.dq_s2;
        end
        // refresh interval: a tick sets the flag even in its clear cycle
        if (st_q.init_done) begin
            if (st_q.ref_tick == REF_INT_CYC) begin
                st_d.ref_tick = '0;
            end else begin
                st_d.ref_tick = st_q.ref_tick + 16'h0001;
            end
        end
        case (st_q.state)
            // power-up pause: mask and clock-gate held high throughout
            S_PAUSE: begin
                if (!st_q.armed) begin
                    tmr_load = 1'b1;
                    tmr_val = TMR_W'(PAUSE_CYCLES);
                    st_d.armed = 1'b1;
                end else if (tmr_expired) begin
                    st_d.state = S_IPRE;
                end
            end
            // first command: precharge of every bank
            S_IPRE: begin
                st_d.strobes = cmd_strobes(CMD_PRE);
                st_d.addr = '0;
                st_d.addr[AUTO_CLOSE_BIT] = 1'b1;
                bk_close_all = 1'b1;
                tmr_load = 1'b1;
                tmr_val = RP_CYC;
                st_d.ret = S_IMRS;
                st_d.state = S_WAIT;
            end
            // power-on mode content is never trusted: always program it
            S_IMRS: begin
                st_d.strobes = cmd_strobes(CMD_MRS);
                st_d.ba = '0;
                st_d.addr = MODE_WORD;
                tmr_load = 1'b1;
                tmr_val = MRD_CYC;
                st_d.ret = S_INOP;
                st_d.state = S_WAIT;
            end
            S_INOP: begin
                st_d.strobes = cmd_strobes(CMD_NOP);
                st_d.ref_left = INIT_REF_COUNT;
                st_d.state = S_IREF;
            end
            // eight refreshes close the startup sequence
            S_IREF: begin
                st_d.strobes = cmd_strobes(CMD_REF);
                st_d.ref_left = st_q.ref_left - 4'h1;
                tmr_load = 1'b1;
                tmr_val = RC_CYC;
                st_d.ret = (st_q.ref_left == 4'h1) ? S_IDLE : S_IREF;
                st_d.state = S_WAIT;
            end
            // taken request first, since ready already promised it
            S_IDLE: begin
                st_d.init_done = 1'b1;
                if (req_valid && st_q.req_ready) begin
                    st_d.l_write = req_write;
                    st_d.l_close = req_auto_close_flag;
                    st_d.l_bank = req_bank;
                    st_d.l_row = req_row;
                    st_d.l_col = req_col;
                    st_d.l_data = req_wdata;
                    st_d.l_be = req_byte_en;
                    if (bk_row_hit) begin
                        st_d.state = S_RW;
                    end else if (bk_is_open) begin
                        st_d.state = S_PRE;
                    end else begin
                        st_d.state = S_ACT;
                    end
                end else if (st_q.ref_due) begin
                    if (bk_any_open) begin
                        st_d.strobes = cmd_strobes(CMD_PRE);
                        st_d.addr[AUTO_CLOSE_BIT] = 1'b1;
                        bk_close_all = 1'b1;
                        tmr_load = 1'b1;
                        tmr_val = RP_CYC;
                        st_d.ret = S_REF;
                        st_d.state = S_WAIT;
                    end else begin
                        st_d.state = S_REF;
                    end
                end else if (pd_req) begin
                    // idle means no burst is running, so no clock suspend
                    st_d.cke = 1'b0;
                    st_d.state = S_PDN;
                end
            end
            // close the wrong row of the target bank only
            S_PRE: begin
                st_d.strobes = cmd_strobes(CMD_PRE);
                st_d.ba = st_q.l_bank;
                st_d.addr[AUTO_CLOSE_BIT] = 1'b0;
                bk_close = 1'b1;
                tmr_load = 1'b1;
                tmr_val = RP_CYC;
                st_d.ret = S_ACT;
                st_d.state = S_WAIT;
            end
            S_ACT: begin
                st_d.strobes = cmd_strobes(CMD_ACT);
                st_d.ba = st_q.l_bank;
                st_d.addr = st_q.l_row;
                bk_open = 1'b1;
                tmr_load = 1'b1;
                tmr_val = RCD_CYC;
                st_d.ret = S_RW;
                st_d.state = S_WAIT;
            end
            // one-word access; masks per byte lane
            S_RW: begin
                st_d.ba = st_q.l_bank;
                st_d.addr = ADDR_W'(st_q.l_col);
                st_d.addr[AUTO_CLOSE_BIT] = st_q.l_close;
                bk_close = st_q.l_close;
                tmr_load = 1'b1;
                st_d.ret = S_IDLE;
                st_d.state = S_WAIT;
                if (st_q.l_write) begin
                    st_d.strobes = cmd_strobes(CMD_WRITE);
                    st_d.dq_o = st_q.l_data;
                    st_d.dq_oe = 1'b1;
                    st_d.mask = ~st_q.l_be;
                    tmr_val = WR_DONE_CYC;
                end else begin
                    st_d.strobes = cmd_strobes(CMD_READ);
                    st_d.mask = '0;
                    tmr_val = RD_DONE_CYC;
                end
            end
            // refresh only with all banks closed and clock-gate high
            S_REF: begin
                st_d.strobes = cmd_strobes(CMD_REF);
                st_d.ref_due = 1'b0;
                tmr_load = 1'b1;
                tmr_val = RC_CYC;
                st_d.ret = S_IDLE;
                st_d.state = S_WAIT;
            end
            // a due refresh also wakes the device; power-down resumes after it while pd_req holds
            S_PDN: begin
                st_d.cke = 1'b0;
                if (!pd_req || st_q.ref_due) begin
                    st_d.cke = 1'b1;
                    st_d.state = S_PDX;
                end
            end
            // clock-gate stays high one cycle before any new command
            S_PDX: begin
                st_d.state = S_IDLE;
            end
            S_WAIT: begin
                if (tmr_expired) begin
                    st_d.state = st_q.ret;
                end
            end
            default: begin
                st_d.state = S_IDLE;
            end
        endcase
        if (st_q.init_done && (st_q.ref_tick == REF_INT_CYC)) begin
            st_d.ref_due = 1'b1;
        end
        st_d.req_ready = (st_d.state == S_IDLE) && st_d.init_done && !st_d.ref_due && !pd_req;
    end

    // ********
    // registers
    // ********
    // reset holds NOP, masks and gate high
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.state <= S_PAUSE;
            st_q.ret <= S_IDLE;
            st_q.cke <= RST_CKE;
            st_q.cs_n <= RST_CS_N;
            st_q.strobes <= RST_STROBES;
            st_q.mask <= RST_MASK;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // ********
    // outputs, all straight from flops
    // ********
    assign req_ready = st_q.req_ready;
    assign rd_valid = st_q.rd_valid;
    assign rd_data = st_q.rd_data;
    assign init_done = st_q.init_done;
    assign sd_clk_gate = st_q.cke;
    assign sd_chip_sel_n = st_q.cs_n;
    assign sd_row_strobe_n = st_q.strobes[2];
    assign sd_col_strobe_n = st_q.strobes[1];
    assign sd_write_n = st_q.strobes[0];
    assign sd_bank_select = st_q.ba;
    assign sd_addr = st_q.addr;
    assign sd_low_byte_mask = st_q.mask[0];
    assign sd_high_byte_mask = st_q.mask[1];
    assign sd_dq_out = st_q.dq_o;
    assign sd_dq_oe = st_q.dq_oe;

endmodule : sdc_ctrl
`default_nettype wire

/* verification/sdc_ctrl_checker.sv */
/* Pin assertions for sdc_ctrl, bound into every instance.
   Assumes PAUSE_CYCLES is handed on from the instance. */
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_checker #(
    parameter int PAUSE_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic req_ready,
    input wire logic init_done,
    input wire logic sd_clk_gate,
    input wire logic sd_chip_sel_n,
    input wire logic sd_row_strobe_n,
    input wire logic sd_col_strobe_n,
    input wire logic sd_write_n,
    input wire logic [sdc_pkg::ADDR_W-1:0] sd_addr,
    input wire logic sd_low_byte_mask,
    input wire logic sd_high_byte_mask,
    input wire logic sd_dq_oe
);
    import sdc_pkg::*;
    typedef struct packed {logic [15:0] cyc; logic [3:0] refs; logic seen; logic pre;} sdc_chk_t;
    sdc_chk_t st_q, st_d;
    logic [3:0] cmd;
    logic masks;
    // ********
    // start-up history
    // ********
    // counted on enabled cycles only, since the pins freeze otherwise
    assign cmd = {sd_chip_sel_n, sd_row_strobe_n, sd_col_strobe_n, sd_write_n};
    assign masks = sd_low_byte_mask & sd_high_byte_mask;
    always_comb begin
        st_d = st_q;
        if (clk_en) begin
            st_d.cyc = (&st_q.cyc) ? st_q.cyc : st_q.cyc + 16'h0001;
            st_d.seen = st_q.seen | (cmd != 4'h7);
            st_d.pre = st_q.pre | (cmd == 4'h2 && sd_addr[10]);
            if (cmd == 4'h1 && !init_done && !(&st_q.refs)) st_d.refs = st_q.refs + 4'h1;
        end
    end
    // helper state register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) st_q <= '0;
        else st_q <= st_d;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_mrs; cmd == 4'h0; endsequence
    sequence s_rd; cmd == 4'h5 && !sd_low_byte_mask && !sd_high_byte_mask; endsequence
    property p_pause; st_q.cyc < PAUSE_CYCLES |-> cmd == 4'h7; endproperty
    a_pause: assert property (p_pause) else $error("command in pause");
    property p_first; !st_q.seen && cmd != 4'h7 |-> cmd == 4'h2 && sd_addr[10]; endproperty
    a_first: assert property (p_first) else $error("first command wrong");
    property p_init_pins; !init_done |-> sd_clk_gate && masks; endproperty
    a_init_pins: assert property (p_init_pins) else $error("mask or gate low");
    property p_mrs_pre; s_mrs |-> st_q.pre; endproperty
    a_mrs_pre: assert property (p_mrs_pre) else $error("mode set too early");
    property p_mrs_nop; s_mrs |=> cmd == 4'h7; endproperty
    a_mrs_nop: assert property (p_mrs_nop) else $error("no idle after mode set");
    property p_refs; $rose(init_done) |-> st_q.refs >= 4'h8 && st_q.pre; endproperty
    a_refs: assert property (p_refs) else $error("too few refreshes");
    property p_ready; !init_done |-> !req_ready; endproperty
    a_ready: assert property (p_ready) else $error("ready before start-up");
    property p_rd; cmd == 4'h5 |-> s_rd ##1 masks; endproperty
    a_rd: assert property (p_rd) else $error("read mask wrong");
    property p_wr_oe; sd_dq_oe |-> cmd == 4'h4; endproperty
    a_wr_oe: assert property (p_wr_oe) else $error("data driven off write");
    property p_ref; cmd == 4'h1 |-> sd_clk_gate && $past(sd_clk_gate); endproperty
    a_ref: assert property (p_ref) else $error("refresh with gate low");
endmodule : sdc_ctrl_checker
bind sdc_ctrl sdc_ctrl_checker #(.PAUSE_CYCLES(PAUSE_CYCLES)) u_chk (.ref_clk, .sys_rst,
    .clk_en, .req_ready, .init_done, .sd_clk_gate, .sd_chip_sel_n, .sd_row_strobe_n,
    .sd_col_strobe_n, .sd_write_n, .sd_addr, .sd_low_byte_mask, .sd_high_byte_mask, .sd_dq_oe);
`default_nettype wire

/* verification/sdc_mem_model.sv */
/* Behavioural x16 memory, four banks, burst one, read latency two.
   Assumes it shares ref_clk with the controller. */
`timescale 1ns/1ps
`default_nettype none
module sdc_mem_model (
    input wire logic ref_clk,
    input wire logic cke,
    input wire logic [3:0] cmd_n,
    input wire logic [1:0] ba,
    input wire logic [11:0] addr,
    input wire logic [1:0] mask,
    input wire logic [15:0] dq_w,
    output logic [15:0] dq_r,
    output logic [7:0] bad_cnt = '0
);
    logic [15:0] mem [int];
    logic [11:0] row [4];
    logic [3:0] open_b = '0;
    logic cke_p = 1'b1;
    logic mode_ok = 1'b0;
    logic [17:0] s1 = '0, s2 = '0;
    logic [15:0] last = '0;
    int key;
    // ********
    // command decode
    // ********
    // gate low or deselect leaves banks, mode and contents alone
    always @(posedge ref_clk) begin
        cke_p <= cke;
        s2 <= s1;
        s1 <= '0;
        last <= dq_r;
        key = {ba, row[ba], addr[8:0]};
        if (cke_p && cke && !cmd_n[3]) begin
            case (cmd_n[2:0])
                3'h3: if (open_b[ba] || !mode_ok) bad_cnt++;
                    else begin
                        open_b[ba] <= 1'b1;
                        row[ba] <= addr;
                    end
                3'h5, 3'h4: if (!open_b[ba]) bad_cnt++;
                    else begin
                        if (!mem.exists(key)) mem[key] = '0;
                        if (cmd_n[0]) s1 <= {~mask, mem[key]};
                        if (!cmd_n[0] && !mask[0]) mem[key][7:0] = dq_w[7:0];
                        if (!cmd_n[0] && !mask[1]) mem[key][15:8] = dq_w[15:8];
                        if (addr[10]) open_b[ba] <= 1'b0;
                    end
                3'h2: if (addr[10]) open_b <= '0;
                    else open_b[ba] <= 1'b0;
                3'h0, 3'h1: if (|open_b) bad_cnt++;
                    else mode_ok <= mode_ok | !cmd_n[0];
                default: ;
            endcase
        end
    end
    // floated lanes flip every cycle so stale data cannot pass
    always_comb begin
        dq_r[7:0] = s2[16] ? s2[7:0] : ~last[7:0];
        dq_r[15:8] = s2[17] ? s2[15:8] : ~last[15:8];
    end
endmodule : sdc_mem_model
`default_nettype wire

/* verification/test_sdc_ctrl.sv */
/* Self-checking bench: sdc_ctrl driving the behavioural memory.
   Assumes one 125 MHz clock for controller and memory. */
`timescale 1ns/1ps
`default_nettype none
module test_sdc_ctrl;
    import sdc_pkg::*;
    logic ref_clk, sys_rst = 1'b1, clk_en = 1'b1, pd_req = 1'b0, req_ac = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, req_ready, rd_valid, init_done;
    logic [1:0] req_bank = '0, req_byte_en = '0, sd_bank_select;
    logic [11:0] req_row = '0, sd_addr;
    logic [8:0] req_col = '0;
    logic [15:0] req_wdata = '0, rd_data, sd_dq_out, sd_dq_in, dq_r;
    logic sd_clk_gate, sd_chip_sel_n, sd_row_strobe_n, sd_col_strobe_n, sd_write_n;
    logic sd_low_byte_mask, sd_high_byte_mask, sd_dq_oe;
    logic [7:0] bad_cnt;
    logic [15:0] shadow [int];
    logic [15:0] exp_q [$];
    logic [22:0] keys [8];
    logic [31:0] seed = 32'h7095;
    int failures = 0, cmp_count = 0;
    // ********
    // design and memory
    // ********
    sdc_ctrl #(.PAUSE_CYCLES(20)) dut (.ref_clk, .sys_rst, .clk_en, .req_valid, .req_ready,
        .req_write, .req_auto_close_flag(req_ac), .req_bank, .req_row, .req_col, .req_wdata,
        .req_byte_en, .pd_req, .rd_valid, .rd_data, .init_done, .sd_clk_gate, .sd_chip_sel_n,
        .sd_row_strobe_n, .sd_col_strobe_n, .sd_write_n, .sd_bank_select, .sd_addr,
        .sd_low_byte_mask, .sd_high_byte_mask, .sd_dq_out, .sd_dq_oe, .sd_dq_in);
    assign sd_dq_in = sd_dq_oe ? sd_dq_out : dq_r;
    sdc_mem_model u_mem (.ref_clk, .cke(sd_clk_gate), .ba(sd_bank_select), .addr(sd_addr),
        .cmd_n({sd_chip_sel_n, sd_row_strobe_n, sd_col_strobe_n, sd_write_n}), .dq_r,
        .mask({sd_high_byte_mask, sd_low_byte_mask}), .dq_w(sd_dq_in), .bad_cnt);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("compares=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic wait_init();
        int n;
        n = 0;
        while (init_done !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        check({15'h0, init_done}, 16'h0001);
    endtask : wait_init
    // one request; read word noted when taken
    task automatic access(input logic w, input logic [22:0] k, input logic [1:0] be,
                          input logic ac);
        logic [31:0] v;
        int n;
        v = xs();
        n = 0;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_ac <= ac;
        {req_bank, req_row, req_col} <= k;
        req_wdata <= v[15:0];
        req_byte_en <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 300);
        if (n >= 300) failures++;
        req_valid <= 1'b0;
        if (!shadow.exists(k)) shadow[k] = '0;
        if (w && be[0]) shadow[k][7:0] = v[7:0];
        if (w && be[1]) shadow[k][15:8] = v[15:8];
        if (!w) exp_q.push_back(shadow[k]);
    endtask : access
    // read results against the oldest note
    always @(posedge ref_clk) begin
        if (rd_valid === 1'b1)
            check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data);
    end
    // hang guard
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_init();
        for (int i = 0; i < 8; i++) begin
            keys[i] = {i[1:0], 21'(xs())};
            access(1'b1, keys[i], 2'h3, i[0]);
        end
        for (int i = 0; i < 8; i++) access(1'b0, keys[i], 2'h3, i[1]);
        for (int i = 0; i < 8; i++) begin
            access(1'b1, keys[i], i[1:0], 1'b0);
            access(1'b0, keys[i], 2'h3, 1'b0);
        end
        repeat (30) @(posedge ref_clk);
        pd_req <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({15'h0, sd_clk_gate}, 16'h0000);
        pd_req <= 1'b0;
        repeat (4) @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        clk_en <= 1'b1;
        repeat (1600) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) access(1'b0, keys[i], 2'h3, 1'b0);
        repeat (30) @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_init();
        access(1'b0, keys[0], 2'h3, 1'b1);
        repeat (30) @(posedge ref_clk);
        check(16'(exp_q.size()), 16'h0000);
        check({8'h0, bad_cnt}, 16'h0000);
        end_of_test();
    end
endmodule : test_sdc_ctrl
`default_nettype wire
